//--- pkg/acc_pkg.sv
// Purpose: constants for the channel configuration and calibration register set
// Assumes: 16-bit register words, word addressing on a plain register port
// Notes: all offsets, field positions and reset values live here
package acc_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ACC_ADDR_W = 8;
   localparam int ACC_DATA_W = 16;
   localparam int ACC_CAL_W = 24;
   localparam int ACC_PHASE_W = 10;

   // ---------------------------------------------------------------
   // register offsets (word addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ACC_OFF_CHANNEL_CONFIG = 8'h18;
   localparam logic [7:0] ACC_OFF_OFFSET_CAL_UPPER = 8'h19;
   localparam logic [7:0] ACC_OFF_OFFSET_CAL_LOWER = 8'h1A;
   localparam logic [7:0] ACC_OFF_GAIN_CAL_UPPER = 8'h1B;
   localparam logic [7:0] ACC_OFF_GAIN_CAL_LOWER = 8'h1C;
   localparam logic [7:0] ACC_OFF_PREV_GAIN_CAL_LOWER = 8'h17;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ACC_PHASE_LSB = 6;
   localparam int ACC_PHASE_MSB = 15;
   localparam int ACC_DCOVR_BIT = 2;
   localparam int ACC_MUX_LSB = 0;
   localparam int ACC_MUX_MSB = 1;
   localparam int ACC_LOWER_LSB = 8;
   localparam int ACC_LOWER_MSB = 15;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] ACC_RST_CHANNEL_CONFIG = 16'h0000;
   localparam logic [15:0] ACC_RST_OFFSET_CAL_UPPER = 16'h0000;
   localparam logic [15:0] ACC_RST_OFFSET_CAL_LOWER = 16'h0000;
   localparam logic [15:0] ACC_RST_GAIN_CAL_UPPER = 16'h8000;
   localparam logic [15:0] ACC_RST_GAIN_CAL_LOWER = 16'h0000;
   localparam logic [15:0] ACC_RST_PREV_GAIN_CAL_LOWER = 16'h0000;

   // writable-bit masks: reserved positions are never stored
   localparam logic [15:0] ACC_MASK_CHANNEL_CONFIG = 16'hFFC7;
   localparam logic [15:0] ACC_MASK_FULL = 16'hFFFF;
   localparam logic [15:0] ACC_MASK_LOWER = 16'hFF00;

   // input selection encodings
   typedef enum logic [1:0] {
      ACC_MUX_PINS = 2'h0,
      ACC_MUX_SHORT = 2'h1,
      ACC_MUX_TEST_POS = 2'h2,
      ACC_MUX_TEST_NEG = 2'h3
   } acc_mux_type;
endpackage

//--- rtl/acc_reg_word.sv
// Purpose: one 16-bit register word with a writable-bit mask
// Assumes: synchronous active-high reset, single clock
// Notes: masked-off bits hold zero forever, whatever is written
`timescale 1ns/1ps
module acc_reg_word #(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] WR_MASK = 16'hFFFF
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic wr_en_i,
   input wire logic [15:0] wr_data_i,
   output logic [15:0] value_o
);
   logic [15:0] word_q;
   logic [15:0] word_d;

   // reserved bits forced to zero on every write
   assign word_d = wr_en_i ? (wr_data_i & WR_MASK) : word_q;

   // storage
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         word_q <= RESET_VAL & WR_MASK;
      end else begin
         word_q <= word_d;
      end
   end

   assign value_o = word_q;
endmodule

//--- rtl/acc_regs.sv
// Purpose: channel configuration and calibration registers of one converter channel
// Assumes: plain register port, read data valid the cycle after the read strobe
// Notes: addresses are matched on their low 8 bits only; unmapped ones read zero and ignore writes
`timescale 1ns/1ps

// Behaviour
// - config bits 15:6 hold signed phase delay in modulator cycles, reset zero.
// - config bit 2 set disables dc filter for this channel, else global.
// - config bits 1:0 pick pins, shorted inputs, positive or negative test.
// - reserved bits are read-only and always read zero.
// - upper offset register holds offset bits 23:8, two's complement, reset zero.
// - lower offset register bits 15:8 hold offset bits 7:0.
// - upper gain register holds gain bits 23:8, reset 8000h for unity.
// - lower gain register bits 15:8 hold gain bits 7:0, reset zero.
// - combined gain is unsigned, spanning zero to just under two.
// - previous channel lower gain register holds its bits 7:0 in 15:8.
// - registers decode at word addresses 18h through 1Ch in order, previous channel lower gain at 17h.
module acc_regs #(
   parameter int ADDR_W = acc_pkg::ACC_ADDR_W
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic global_dc_filter_setting_i,
   output logic [9:0] phase_delay_field_o,
   output logic dc_filter_enable_o,
   output logic dc_filter_override_o,
   output logic [1:0] input_select_field_o,
   output logic sel_input_pins_o,
   output logic sel_short_o,
   output logic sel_test_pos_o,
   output logic sel_test_neg_o,
   output logic [23:0] offset_cal_o,
   output logic [23:0] gain_cal_o,
   output logic [23:0] prev_gain_cal_low_o
);
   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   localparam int NREG = 6;
   logic [NREG-1:0] hit;
   logic [NREG-1:0] wr_sel;
   logic [15:0] word [NREG];
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   wire logic [7:0] addr8 = 8'(addr_i);
   assign hit[0] = (addr8 == acc_pkg::ACC_OFF_CHANNEL_CONFIG);
   assign hit[1] = (addr8 == acc_pkg::ACC_OFF_OFFSET_CAL_UPPER);
   assign hit[2] = (addr8 == acc_pkg::ACC_OFF_OFFSET_CAL_LOWER);
   assign hit[3] = (addr8 == acc_pkg::ACC_OFF_GAIN_CAL_UPPER);
   assign hit[4] = (addr8 == acc_pkg::ACC_OFF_GAIN_CAL_LOWER);
   assign hit[5] = (addr8 == acc_pkg::ACC_OFF_PREV_GAIN_CAL_LOWER);
   assign wr_sel = hit & {NREG{wr_i}};

   // ---------------------------------------------------------------
   // register words
   // ---------------------------------------------------------------
   // config: reserved bits 5:3 masked out of storage
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_CHANNEL_CONFIG),
      .WR_MASK(acc_pkg::ACC_MASK_CHANNEL_CONFIG)
   ) u_cfg (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[0]),
      .wr_data_i(wdata_i),
      .value_o(word[0])
   );

   // upper offset, all 16 bits writable
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_OFFSET_CAL_UPPER),
      .WR_MASK(acc_pkg::ACC_MASK_FULL)
   ) u_ocal_up (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[1]),
      .wr_data_i(wdata_i),
      .value_o(word[1])
   );

   // lower offset, low byte reserved
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_OFFSET_CAL_LOWER),
      .WR_MASK(acc_pkg::ACC_MASK_LOWER)
   ) u_ocal_lo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[2]),
      .wr_data_i(wdata_i),
      .value_o(word[2])
   );

   // upper gain, resets to unity
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_GAIN_CAL_UPPER),
      .WR_MASK(acc_pkg::ACC_MASK_FULL)
   ) u_gcal_up (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[3]),
      .wr_data_i(wdata_i),
      .value_o(word[3])
   );

   // lower gain, low byte reserved
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_GAIN_CAL_LOWER),
      .WR_MASK(acc_pkg::ACC_MASK_LOWER)
   ) u_gcal_lo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[4]),
      .wr_data_i(wdata_i),
      .value_o(word[4])
   );

   // previous channel lower gain, same layout
   acc_reg_word #(
      .RESET_VAL(acc_pkg::ACC_RST_PREV_GAIN_CAL_LOWER),
      .WR_MASK(acc_pkg::ACC_MASK_LOWER)
   ) u_prev_gcal_lo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel[5]),
      .wr_data_i(wdata_i),
      .value_o(word[5])
   );

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // one-hot select; unmapped addresses give zero
   always_comb begin
      rdata_d = 16'h0000;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            rdata_d = word[i];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rd_i ? rdata_d : 16'h0000;
      end
   end
   assign rdata_o = rdata_q;

   // ---------------------------------------------------------------
   // field outputs to the datapath
   // ---------------------------------------------------------------
   // phase delay kept as raw two's complement
   assign phase_delay_field_o = word[0][acc_pkg::ACC_PHASE_MSB:acc_pkg::ACC_PHASE_LSB];
   assign dc_filter_override_o = word[0][acc_pkg::ACC_DCOVR_BIT];
   // override only ever turns the filter off; zero defers to the global setting
   assign dc_filter_enable_o = global_dc_filter_setting_i & ~dc_filter_override_o;
   assign input_select_field_o = word[0][acc_pkg::ACC_MUX_MSB:acc_pkg::ACC_MUX_LSB];
   assign sel_input_pins_o = (input_select_field_o == acc_pkg::ACC_MUX_PINS);
   assign sel_short_o = (input_select_field_o == acc_pkg::ACC_MUX_SHORT);
   assign sel_test_pos_o = (input_select_field_o == acc_pkg::ACC_MUX_TEST_POS);
   assign sel_test_neg_o = (input_select_field_o == acc_pkg::ACC_MUX_TEST_NEG);

   // 24-bit values: upper word is bits 23:8, lower byte from 15:8
   assign offset_cal_o = {word[1], word[2][acc_pkg::ACC_LOWER_MSB:acc_pkg::ACC_LOWER_LSB]};
   // gain is unsigned; 800000h is unity, full scale just under two
   assign gain_cal_o = {word[3], word[4][acc_pkg::ACC_LOWER_MSB:acc_pkg::ACC_LOWER_LSB]};
   // only the low byte of the previous channel lives here
   assign prev_gain_cal_low_o = {16'h0000,
      word[5][acc_pkg::ACC_LOWER_MSB:acc_pkg::ACC_LOWER_LSB]};
endmodule

//--- verification/acc_regs_assertions.sv
// Purpose: port checks for the channel register set
// Assumes: one clock, sync active-high reset
// Notes: bound below its endmodule
`timescale 1ns/1ps
module acc_regs_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic global_dc_filter_setting_i,
   input wire logic [9:0] phase_delay_field_o,
   input wire logic dc_filter_enable_o,
   input wire logic dc_filter_override_o,
   input wire logic [1:0] input_select_field_o,
   input wire logic [23:0] offset_cal_o,
   input wire logic [23:0] gain_cal_o
);
   // config word as it must read, reserved bits forced low
   wire [15:0] cfg = {phase_delay_field_o, 3'h0, dc_filter_override_o, input_select_field_o};
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   // reads show the stored words one cycle later
   cfg_read_a: assert property (rd_i && addr_i == 8'h18 |=> rdata_o == cfg)
      else $error("config read wrong");
   off_low_a: assert property (rd_i && addr_i == 8'h1A |=> rdata_o == {offset_cal_o[7:0], 8'h00})
      else $error("offset low read wrong");
   gain_low_a: assert property (rd_i && addr_i == 8'h1C |=> rdata_o == {gain_cal_o[7:0], 8'h00})
      else $error("gain low read wrong");
   // idle cycles and holes in the map read zero
   idle_zero_a: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("read data not cleared");
   unmapped_a: assert property (rd_i && !(addr_i inside {[8'h17:8'h1C]}) |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   // writes land next cycle, reserved bits dropped
   cfg_write_a: assert property (wr_i && addr_i == 8'h18 |=> cfg == ($past(wdata_i) & 16'hFFC7))
      else $error("config write wrong");
   off_write_a: assert property (wr_i && addr_i == 8'h19 |=> offset_cal_o[23:8] == $past(wdata_i))
      else $error("offset upper write wrong");
   dc_enable_a: assert property (dc_filter_enable_o ==
      (global_dc_filter_setting_i & ~dc_filter_override_o)) else $error("dc filter enable wrong");
   reset_val_a: assert property ($fell(srst_i) |-> gain_cal_o == 24'h800000 && cfg == 16'h0000)
      else $error("reset values wrong");
endmodule

bind acc_regs acc_regs_checker #(
   .ADDR_W(ADDR_W)
) i_acc_regs_checker (
   .clock_i(clock_i),
   .srst_i(srst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .global_dc_filter_setting_i(global_dc_filter_setting_i),
   .phase_delay_field_o(phase_delay_field_o),
   .dc_filter_enable_o(dc_filter_enable_o),
   .dc_filter_override_o(dc_filter_override_o),
   .input_select_field_o(input_select_field_o),
   .offset_cal_o(offset_cal_o),
   .gain_cal_o(gain_cal_o)
);

//--- verification/tb.sv
// Purpose: self-checking bench for the channel register set
// Assumes: 20 MHz clock, reset held five cycles
// Notes: accesses start 1 ns after an edge, the first one at the reset-release edge itself, and hold to the next edge
`timescale 1ns/1ps
module tb;
   logic clock_i = 1'h0;
   logic srst_i = 1'h1;
   logic wr_i = 1'h0;
   logic rd_i = 1'h0;
   logic global_dc_filter_setting_i = 1'h1;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic [15:0] rdata_o;
   logic [9:0] phase_delay_field_o;
   logic dc_filter_enable_o, dc_filter_override_o;
   logic sel_input_pins_o, sel_short_o, sel_test_pos_o, sel_test_neg_o;
   logic [1:0] input_select_field_o;
   logic [23:0] offset_cal_o, gain_cal_o, prev_gain_cal_low_o;
   int error_cnt = 0;
   int n_checks = 0;
   logic [7:0] adr [6] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
   logic [15:0] msk [6] = '{16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
   logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
   wire [3:0] sel = {sel_input_pins_o, sel_short_o, sel_test_pos_o, sel_test_neg_o};

   acc_regs i_acc_regs (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .global_dc_filter_setting_i(global_dc_filter_setting_i),
      .phase_delay_field_o(phase_delay_field_o),
      .dc_filter_enable_o(dc_filter_enable_o),
      .dc_filter_override_o(dc_filter_override_o),
      .input_select_field_o(input_select_field_o),
      .sel_input_pins_o(sel_input_pins_o),
      .sel_short_o(sel_short_o),
      .sel_test_pos_o(sel_test_pos_o),
      .sel_test_neg_o(sel_test_neg_o),
      .offset_cal_o(offset_cal_o),
      .gain_cal_o(gain_cal_o),
      .prev_gain_cal_low_o(prev_gain_cal_low_o)
   );

   // 50 ns period
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobe left high so a following call needs no gap cycle
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      wr_i <= w;
      rd_i <= ~w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      acc(1'h0, a, 16'h0000);
      chk("rdata", {8'h00, exp}, {8'h00, rdata_o});
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clock_i);
      srst_i <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], rv[i]);
      end
      chk("gain", 24'h800000, gain_cal_o);
      // back-to-back write then read, reserved bits must stay low
      for (int i = 0; i < 6; i++) begin
         acc(1'h1, adr[i], 16'hFFFF);
         rd(adr[i], msk[i]);
         acc(1'h1, adr[i], 16'h1234);
         rd(adr[i], 16'h1234 & msk[i]);
      end
      acc(1'h1, 8'h19, 16'h8001);
      acc(1'h1, 8'h1A, 16'hABFF);
      acc(1'h1, 8'h1B, 16'hFFFF);
      acc(1'h1, 8'h1C, 16'hFEFF);
      acc(1'h1, 8'h17, 16'h3355);
      chk("offset", 24'h8001AB, offset_cal_o);
      chk("gain", 24'hFFFFFE, gain_cal_o);
      chk("prev", 24'h000033, prev_gain_cal_low_o);
      // holes around the map must not alias
      acc(1'h1, 8'h1D, 16'hFFFF);
      acc(1'h1, 8'h16, 16'h0000);
      rd(8'h1D, 16'h0000);
      rd(8'h19, 16'h8001);
      // every input selection, override toggling against global
      for (int m = 0; m < 4; m++) begin
         global_dc_filter_setting_i <= m[1];
         acc(1'h1, 8'h18, {10'h201, 3'h7, m[0], m[1:0]});
         chk("phase", 24'h000201, {14'h0000, phase_delay_field_o});
         chk("select", 24'h000008 >> m, {20'h00000, sel});
         chk("filter", {23'h0, m[1] & ~m[0]}, {23'h0, dc_filter_enable_o});
      end
      // reset in mid-run
      wr_i <= 1'h0;
      srst_i <= 1'h1;
      @(posedge clock_i);
      srst_i <= 1'h0;
      #1;
      chk("gain", 24'h800000, gain_cal_o);
      chk("phase", 24'h000000, {14'h0000, phase_delay_field_o});
      // first access after the second release, also lets the checker see the fall
      rd(8'h1B, 16'h8000);
      finish_test();
   end
   // hang guard, run needs about 50 cycles
   initial begin
      repeat (2000) @(posedge clock_i);
      error_cnt++;
      finish_test();
   end
endmodule
